/* clkgen_defs.svh */
// Constants of the clock generator: offsets, field positions, reset values, timing.
// Assumes a 125 MHz system clock that samples the oscillator pin and times all counts.
`ifndef CLKGEN_DEFS_SVH
`define CLKGEN_DEFS_SVH

// Register byte addresses
`define ADDR_SYSTEM_CONFIG 8'h00
`define ADDR_STATUS 8'h04

// system_config_reg fields
`define CFG_SUPERVISOR_DISABLE 0
`define CFG_IDLE 1
`define CFG_POWER_DOWN 2
`define CFG_RESET 3'h0

// Status fields
`define ST_STRAP_LSB 0
`define ST_LOCKED 3
`define ST_FAILOVER 4
`define ST_SOURCE_LSB 5

// Strap codes
`define STRAP_DIRECT 3'h3
`define STRAP_PRESCALE 3'h1

// Timing
`define SYS_CLOCK_KHZ 125000
`define LOCK_TIME_US 1000
`define LOCK_CYCLES ((`LOCK_TIME_US * `SYS_CLOCK_KHZ) / 1000)
`define LOOP_BASIC_KHZ 5000
`define LOOP_FREE_HALF (`SYS_CLOCK_KHZ / (2 * `LOOP_BASIC_KHZ))
`define SUPERVISOR_OVERFLOW 5'h10
`define PERIOD_TOLERANCE 16'h0002
`define PERIOD_MAX 16'hFFFF

`endif

/* clkgen_pkg.sv */
// Types shared by the clock generator modules.
// Assumes clkgen_defs.svh for all numeric constants.
package clkgen_pkg;

    typedef enum logic [1:0] {SRC_LOOP, SRC_DIRECT, SRC_PRESCALE} clk_source_t;

    typedef enum logic [1:0] {LOOP_OFF, LOOP_FREE, LOOP_ACQUIRE, LOOP_LOCKED} loop_state_t;

endpackage : clkgen_pkg

/* sync3.sv */
// Three-stage synchroniser for pin inputs.
// Assumes input is asynchronous; output moves only when stages two and three agree.
`timescale 1ns/10ps
module sync3 #(
    parameter int W = 1
) (
    // Clock
    input wire logic clock,
    // Data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    always_ff @(posedge clock) begin
        stage1 <= din;
        stage2 <= stage1;
        stage3 <= stage2;
        if (stage2 == stage3) begin
            dout <= stage3;
        end
    end
endmodule : sync3

/* half_period_gen.sv */
// Square-wave generator with programmable half period in system clocks.
// Assumes halfPeriod of at least one; disabled output rests low.
`timescale 1ns/10ps
module half_period_gen (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Control
    input wire logic enable,
    input wire logic [15:0] halfPeriod,
    // Wave
    output logic level,
    output logic rise
);
    logic [15:0] count;

    // Equal high and low halves give the even duty cycle
    always_ff @(posedge clock) begin
        if (rst || !enable) begin
            count <= 16'h0000;
            level <= 1'b0;
            rise <= 1'b0;
        end else if (count + 16'h0001 >= halfPeriod) begin
            count <= 16'h0000;
            level <= ~level;
            rise <= ~level;
        end else begin
            count <= count + 16'h0001;
            rise <= 1'b0;
        end
    end
endmodule : half_period_gen

/* pll_clock_generator.sv */
// Clock generator: strap decode, loop model, oscillator supervisor, clock gating.
// Assumes a 125 MHz system clock much faster than the oscillator pin, AXI4-Lite master.
`timescale 1ns/10ps
`include "clkgen_defs.svh"
module pll_clock_generator #(
    parameter int LOCK_WAIT_CYCLES = `LOCK_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Pins
    input wire logic oscillatorInputPin,
    input wire logic [2:0] clockSelectStraps,
    // Generated clocks and request
    output logic cpuClock,
    output logic periphClock,
    output logic clockFailIrqNode,
    // AXI4-Lite write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    import clkgen_pkg::*;

    logic oscLevel;
    logic oscLast;
    logic oscRise;
    logic oscToggle;
    logic [2:0] strapSync;
    logic [2:0] strap;
    logic [2:0] sysConfig;
    logic bypassStrap;
    logic [4:0] mult2;
    logic [15:0] periodCount;
    logic [15:0] lastPeriod;
    logic periodStable;
    logic inputLost;
    loop_state_t loopState;
    logic [16:0] lockCount;
    logic [15:0] loopHalf;
    logic loopLevel;
    logic loopRise;
    logic [4:0] supervisorCount;
    logic failover;
    logic prescLevel;
    clk_source_t source;
    clk_source_t targetSource;
    logic sourceLevel;
    logic targetLevel;
    logic clkLevel;
    logic cpuGate;
    logic periphGate;
    logic awHeld;
    logic wHeld;
    logic [7:0] wrAddr;
    logic [31:0] wrData;
    logic wrStrb0;

    sync3 #(.W(1)) oscSync (
        .clock(clock),
        .din(oscillatorInputPin),
        .dout(oscLevel)
    );

    sync3 #(.W(3)) strapSyncInst (
        .clock(clock),
        .din(clockSelectStraps),
        .dout(strapSync)
    );

    // Straps follow the pins only while reset is held
    always_ff @(posedge clock) begin
        if (rst) begin
            strap <= strapSync;
        end
    end

    assign bypassStrap = (strap == `STRAP_DIRECT) || (strap == `STRAP_PRESCALE);

    // Factor times two, so that x0.5 and x2.5 stay integral
    always_comb begin
        case (strap)
            3'h7: mult2 = 5'h08;
            3'h6: mult2 = 5'h06;
            3'h5: mult2 = 5'h04;
            3'h4: mult2 = 5'h0A;
            3'h3: mult2 = 5'h02;
            3'h2: mult2 = 5'h14;
            3'h1: mult2 = 5'h01;
            default: mult2 = 5'h05;
        endcase
    end

    // Input edge detection and period measurement
    always_ff @(posedge clock) begin
        oscLast <= oscLevel;
    end
    assign oscRise = oscLevel && !oscLast;
    assign oscToggle = oscLevel != oscLast;

    always_ff @(posedge clock) begin
        if (rst) begin
            periodCount <= 16'h0000;
            lastPeriod <= 16'h0000;
            periodStable <= 1'b0;
        end else if (oscRise) begin
            periodCount <= 16'h0001;
            lastPeriod <= periodCount;
            periodStable <= (periodCount <= lastPeriod + `PERIOD_TOLERANCE)
                && (periodCount + `PERIOD_TOLERANCE >= lastPeriod);
        end else if (periodCount != `PERIOD_MAX) begin
            periodCount <= periodCount + 16'h0001;
        end
    end

    // No edge for twice the last period counts as a lost input
    assign inputLost = (periodCount == `PERIOD_MAX)
        || ({1'b0, periodCount} > {lastPeriod, 1'b0});

    // Loop state: free-running until the input is steady, then lock
    always_ff @(posedge clock) begin
        if (rst) begin
            loopState <= LOOP_FREE;
            lockCount <= 17'h00000;
        end else begin
            case (loopState)
                LOOP_OFF: begin
                    loopState <= LOOP_OFF;
                end
                LOOP_FREE: begin
                    lockCount <= 17'h00000;
                    if (sysConfig[`CFG_SUPERVISOR_DISABLE]) begin
                        loopState <= LOOP_OFF;
                    end else if (oscRise && !bypassStrap) begin
                        loopState <= LOOP_ACQUIRE;
                    end
                end
                LOOP_ACQUIRE: begin
                    if (sysConfig[`CFG_SUPERVISOR_DISABLE]) begin
                        loopState <= LOOP_OFF;
                    end else if (inputLost || (oscRise && !periodStable)) begin
                        loopState <= LOOP_FREE;
                    end else if (lockCount >= 17'(LOCK_WAIT_CYCLES - 1)) begin
                        loopState <= LOOP_LOCKED;
                    end else begin
                        lockCount <= lockCount + 17'h00001;
                    end
                end
                LOOP_LOCKED: begin
                    if (sysConfig[`CFG_SUPERVISOR_DISABLE]) begin
                        loopState <= LOOP_OFF;
                    end else if (inputLost || (oscRise && !periodStable)) begin
                        loopState <= LOOP_FREE;
                    end
                end
                default: loopState <= LOOP_FREE;
            endcase
        end
    end

    // Locked loop output: input period over twice the factor, never below one
    always_comb begin
        loopHalf = 16'(`LOOP_FREE_HALF);
        if (loopState == LOOP_LOCKED) begin
            loopHalf = lastPeriod / {11'h000, mult2};
            if (loopHalf == 16'h0000) begin
                loopHalf = 16'h0001;
            end
        end
    end

    half_period_gen loopGen (
        .clock(clock),
        .rst(rst),
        .enable(loopState != LOOP_OFF),
        .halfPeriod(loopHalf),
        .level(loopLevel),
        .rise(loopRise)
    );

    // Oscillator supervisor counts loop cycles between input transitions
    always_ff @(posedge clock) begin
        if (rst) begin
            supervisorCount <= 5'h00;
            failover <= 1'b0;
        end else if (bypassStrap && !sysConfig[`CFG_SUPERVISOR_DISABLE] && !failover) begin
            if (oscToggle) begin
                supervisorCount <= 5'h00;
            end else if (loopRise) begin
                if (supervisorCount + 5'h01 >= `SUPERVISOR_OVERFLOW) begin
                    failover <= 1'b1;
                end
                supervisorCount <= supervisorCount + 5'h01;
            end
        end
    end

    // Failure request: loss of lock or supervisor overflow
    always_ff @(posedge clock) begin
        if (rst) begin
            clockFailIrqNode <= 1'b0;
        end else begin
            clockFailIrqNode <= (loopState == LOOP_LOCKED && !sysConfig[`CFG_SUPERVISOR_DISABLE]
                && (inputLost || (oscRise && !periodStable)))
                || (bypassStrap && !sysConfig[`CFG_SUPERVISOR_DISABLE] && !failover && !oscToggle
                && loopRise && supervisorCount + 5'h01 >= `SUPERVISOR_OVERFLOW);
        end
    end

    // Prescaler halves the input
    always_ff @(posedge clock) begin
        if (rst) begin
            prescLevel <= 1'b0;
        end else if (oscRise) begin
            prescLevel <= ~prescLevel;
        end
    end

    // Wanted source
    always_comb begin
        targetSource = SRC_LOOP;
        if (sysConfig[`CFG_SUPERVISOR_DISABLE]) begin
            targetSource = (strap == `STRAP_PRESCALE) ? SRC_PRESCALE : SRC_DIRECT;
        end else if (bypassStrap && !failover) begin
            targetSource = (strap == `STRAP_PRESCALE) ? SRC_PRESCALE : SRC_DIRECT;
        end
    end

    function automatic logic levelOf(input clk_source_t s, input logic l,
                                     input logic d, input logic p);
        case (s)
            SRC_DIRECT: levelOf = d;
            SRC_PRESCALE: levelOf = p;
            default: levelOf = l;
        endcase
    endfunction : levelOf

    assign sourceLevel = levelOf(source, loopLevel, oscLevel, prescLevel);
    assign targetLevel = levelOf(targetSource, loopLevel, oscLevel, prescLevel);

    // Handover only while the held output and the new source both sit low, so no short pulse escapes
    always_ff @(posedge clock) begin
        if (rst) begin
            source <= SRC_LOOP;
            clkLevel <= 1'b0;
        end else if (source != targetSource) begin
            // Finish the running high phase of the old source before holding low
            clkLevel <= clkLevel && sourceLevel;
            if (!clkLevel && !targetLevel) begin
                source <= targetSource;
            end
        end else begin
            clkLevel <= sourceLevel;
        end
    end

    // Gates change only while the base clock is low
    always_ff @(posedge clock) begin
        if (rst) begin
            cpuGate <= 1'b1;
            periphGate <= 1'b1;
        end else if (!clkLevel) begin
            cpuGate <= !sysConfig[`CFG_IDLE] && !sysConfig[`CFG_POWER_DOWN];
            periphGate <= !sysConfig[`CFG_POWER_DOWN];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cpuClock <= 1'b0;
            periphClock <= 1'b0;
        end else begin
            cpuClock <= clkLevel && cpuGate;
            periphClock <= clkLevel && periphGate;
        end
    end

    // AXI4-Lite write: address and data taken in either order
    always_ff @(posedge clock) begin
        if (rst) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
            wrAddr <= 8'h00;
            wrData <= 32'h00000000;
            wrStrb0 <= 1'b0;
            sysConfig <= `CFG_RESET;
        end else begin
            awready <= !awHeld && !bvalid && !(awvalid && awready);
            wready <= !wHeld && !bvalid && !(wvalid && wready);
            if (awvalid && awready) begin
                awHeld <= 1'b1;
                wrAddr <= awaddr;
            end
            if (wvalid && wready) begin
                wHeld <= 1'b1;
                wrData <= wdata;
                wrStrb0 <= wstrb[0];
            end
            if (awHeld && wHeld && !bvalid) begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                bvalid <= 1'b1;
                bresp <= 2'h0;
                if (wrAddr == `ADDR_SYSTEM_CONFIG) begin
                    if (wrStrb0) begin
                        sysConfig <= wrData[2:0];
                    end
                end else if (wrAddr != `ADDR_STATUS) begin
                    bresp <= 2'h2;
                end
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read
    always_ff @(posedge clock) begin
        if (rst) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= 2'h0;
        end else begin
            arready <= !rvalid && !(arvalid && arready);
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rresp <= 2'h0;
                rdata <= 32'h00000000;
                if (araddr == `ADDR_SYSTEM_CONFIG) begin
                    rdata <= {29'h00000000, sysConfig};
                end else if (araddr == `ADDR_STATUS) begin
                    rdata <= {25'h0000000, source, failover,
                              loopState == LOOP_LOCKED, strap};
                end else begin
                    rresp <= 2'h2;
                end
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end
endmodule : pll_clock_generator

/* osc_source.sv */
// Oscillator source driving the clock generator's input pin.
// Assumes run changes only after a system clock edge.
`timescale 1ns/10ps
module osc_source #(
    parameter int HALF_NS = 144
) (
    // Control
    input wire logic run,
    // Pin
    output logic oscPin
);
    // Edges land 2 ns before a system clock edge, so measured periods stay exact
    initial begin
        oscPin = 1'b0;
        #2;
        forever begin
            if (run) begin
                #(HALF_NS);
                oscPin = ~oscPin;
            end else begin
                // A failed crystal stands still, low
                oscPin = 1'b0;
                #8;
            end
        end
    end
endmodule : osc_source

/* pll_clock_generator_checker.sv */
// Assertions on the clock generator's clocks, request and bus answers.
// Assumes write address and write data are offered together.
`timescale 1ns/10ps
module pll_clock_generator_checker #(
    parameter int LOCK_WAIT_CYCLES = 50
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Pins and clocks
    input wire logic [2:0] clockSelectStraps,
    input wire logic cpuClock,
    input wire logic periphClock,
    input wire logic clockFailIrqNode,
    // Bus
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid
);
    logic [2:0] strapSeen;
    logic wrBoth;
    logic rdTaken;
    assign wrBoth = awvalid && awready && wvalid && wready;
    assign rdTaken = arvalid && arready;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Pins hold still through reset, so the last sample is the latched code
    always_ff @(posedge clock) begin
        if (rst) begin
            strapSeen <= clockSelectStraps;
        end
    end
    a_irq_one_pulse: assert property (clockFailIrqNode |=> !clockFailIrqNode)
        else $error("clock failure request longer than one cycle");
    a_cpu_needs_periph: assert property (cpuClock |-> periphClock)
        else $error("cpu clock high while peripheral clock low");
    a_read_latency: assert property (rdTaken |=> rvalid)
        else $error("read answer not one cycle after address");
    a_write_latency: assert property (wrBoth |-> ##2 bvalid)
        else $error("write answer not two cycles after request");
    a_ar_ready_drop: assert property (rdTaken |=> !arready)
        else $error("read address ready not dropped after handshake");
    a_read_unmapped: assert property (rdTaken && !(araddr inside {8'h00, 8'h04})
        |=> rresp == 2'b10 && rdata == 32'h0)
        else $error("unmapped read not refused");
    a_write_unmapped: assert property (wrBoth && !(awaddr inside {8'h00, 8'h04})
        |-> ##2 bresp == 2'b10)
        else $error("unmapped write not refused");
    a_read_mapped: assert property (rdTaken && araddr inside {8'h00, 8'h04} |=> rresp == 2'b00)
        else $error("mapped read refused");
    a_strap_status: assert property (rdTaken && araddr == 8'h04 |=> rdata[2:0] == strapSeen)
        else $error("status strap field differs from reset pins");
endmodule : pll_clock_generator_checker

bind pll_clock_generator pll_clock_generator_checker #(
    .LOCK_WAIT_CYCLES(LOCK_WAIT_CYCLES)
) checkerInst (
    .clock(clock), .rst(rst), .clockSelectStraps(clockSelectStraps),
    .cpuClock(cpuClock), .periphClock(periphClock), .clockFailIrqNode(clockFailIrqNode),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid)
);

/* testbench.sv */
// Self-checking bench of the clock generator over AXI4-Lite.
// Assumes osc_source as oscillator and the bound checker.
`timescale 1ns/10ps
`include "clkgen_defs.svh"
module testbench;
    import clkgen_pkg::*;
    logic clock, rst, oscRun, oscillatorInputPin, cpuClock, periphClock, clockFailIrqNode;
    logic [2:0] clockSelectStraps;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    int mismatches;
    int comparisons;
    // Expected cpu half period per strap code with a 36-clock input period
    logic [7:0] halfExp [8] = '{8'h07, 8'h24, 8'h01, 8'h12, 8'h03, 8'h09, 8'h06, 8'h04};
    logic [1:0] srcExp [8] = '{2'h0, 2'h2, 2'h0, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0};

    osc_source #(.HALF_NS(144)) osc (.run(oscRun), .oscPin(oscillatorInputPin));
    pll_clock_generator #(.LOCK_WAIT_CYCLES(50)) DUT (
        .clock(clock), .rst(rst), .oscillatorInputPin(oscillatorInputPin),
        .clockSelectStraps(clockSelectStraps), .cpuClock(cpuClock), .periphClock(periphClock),
        .clockFailIrqNode(clockFailIrqNode), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check

    task automatic do_reset(input logic [2:0] code);
        rst <= 1'b1;
        clockSelectStraps <= code;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        clockSelectStraps <= ~code;
        @(posedge clock);
    endtask : do_reset

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic awOpen;
        logic wOpen;
        @(posedge clock);
        awOpen = 1'b1;
        wOpen = 1'b1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (awOpen || wOpen) begin
            @(posedge clock);
            if (awOpen && awready === 1'b1) begin
                awOpen = 1'b0;
                awvalid <= 1'b0;
            end
            if (wOpen && wready === 1'b1) begin
                wOpen = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clock); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clock); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_read

    task automatic status(output logic [31:0] s);
        logic [1:0] r;
        axi_read(`ADDR_STATUS, s, r);
    endtask : status

    task automatic half_runs(output int hi, output int lo);
        hi = 0;
        lo = 0;
        do @(posedge clock); while (cpuClock !== 1'b0);
        do @(posedge clock); while (cpuClock !== 1'b1);
        while (cpuClock === 1'b1) begin
            hi++;
            @(posedge clock);
        end
        while (cpuClock === 1'b0) begin
            lo++;
            @(posedge clock);
        end
    endtask : half_runs

    task automatic count_rises(output int cpuN, output int perN);
        logic cpuOld;
        logic perOld;
        // Gates only move while the base clock is low
        repeat (30) @(posedge clock);
        cpuN = 0;
        perN = 0;
        cpuOld = cpuClock;
        perOld = periphClock;
        repeat (100) begin
            @(posedge clock);
            cpuN += int'(cpuClock === 1'b1 && cpuOld === 1'b0);
            perN += int'(periphClock === 1'b1 && perOld === 1'b0);
            cpuOld = cpuClock;
            perOld = periphClock;
        end
    endtask : count_rises

    task automatic wait_irq(input int limit);
        int n;
        n = 0;
        while (clockFailIrqNode !== 1'b1 && n < limit) begin
            @(posedge clock);
            n++;
        end
        check({31'h0, clockFailIrqNode}, 32'h1);
    endtask : wait_irq

    task automatic wait_lock;
        logic [31:0] s;
        int n;
        n = 0;
        s = 32'h0;
        while (s[`ST_LOCKED] !== 1'b1 && n < 200) begin
            status(s);
            n++;
        end
        check({31'h0, s[`ST_LOCKED]}, 32'h1);
    endtask : wait_lock

    task automatic test_bus;
        logic [31:0] d;
        logic [1:0] r;
        int hi;
        int lo;
        do_reset(3'h7);
        half_runs(hi, lo);
        check(32'(hi), 32'(`LOOP_FREE_HALF));
        check(32'(lo), 32'(`LOOP_FREE_HALF));
        axi_read(`ADDR_SYSTEM_CONFIG, d, r);
        check(d, 32'h0);
        axi_write(`ADDR_STATUS, 32'h0000_00FF, r);
        check({30'h0, r}, 32'h0);
        axi_read(8'h08, d, r);
        check({30'h0, r}, 32'h2);
        axi_write(8'h0C, 32'h0000_0007, r);
        check({30'h0, r}, 32'h2);
        axi_write(`ADDR_SYSTEM_CONFIG, 32'hFFFF_FFF8, r);
        axi_read(`ADDR_SYSTEM_CONFIG, d, r);
        check(d, 32'h0);
    endtask : test_bus

    task automatic test_straps;
        logic [31:0] s;
        int hi;
        int lo;
        oscRun <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            do_reset(3'(c));
            // Software waits for lock before relying on the selected clock
            if (c != 1 && c != 3) wait_lock();
            // Bypass handover waits for the new source to sit low
            else repeat (40) @(posedge clock);
            status(s);
            check({29'h0, s[2:0]}, 32'(c));
            check({30'h0, s[`ST_SOURCE_LSB +: 2]}, {30'h0, srcExp[c]});
            half_runs(hi, lo);
            check(32'(hi), {24'h0, halfExp[c]});
            check(32'(lo), {24'h0, halfExp[c]});
        end
        // Last code 7 is a loop mode, now locked
        oscRun <= 1'b0;
        wait_irq(300);
        status(s);
        check({31'h0, s[`ST_LOCKED]}, 32'h0);
        half_runs(hi, lo);
        check(32'(hi), 32'(`LOOP_FREE_HALF));
    endtask : test_straps

    task automatic test_gates;
        logic [1:0] r;
        int cpuN;
        int perN;
        axi_write(`ADDR_SYSTEM_CONFIG, 32'h0000_0002, r);
        count_rises(cpuN, perN);
        check({31'h0, cpuN == 0 && perN > 0}, 32'h1);
        axi_write(`ADDR_SYSTEM_CONFIG, 32'h0000_0004, r);
        count_rises(cpuN, perN);
        check({31'h0, cpuN == 0 && perN == 0}, 32'h1);
        axi_write(`ADDR_SYSTEM_CONFIG, 32'h0000_0000, r);
        count_rises(cpuN, perN);
        check({31'h0, cpuN > 0 && perN > 0}, 32'h1);
    endtask : test_gates

    task automatic test_failover;
        logic [31:0] s;
        int hi;
        int lo;
        oscRun <= 1'b1;
        do_reset(`STRAP_DIRECT);
        repeat (200) @(posedge clock);
        oscRun <= 1'b0;
        wait_irq(600);
        oscRun <= 1'b1;
        repeat (300) @(posedge clock);
        status(s);
        check({31'h0, s[`ST_FAILOVER]}, 32'h1);
        check({30'h0, s[`ST_SOURCE_LSB +: 2]}, {30'h0, SRC_LOOP});
        half_runs(hi, lo);
        check(32'(hi), 32'(`LOOP_FREE_HALF));
    endtask : test_failover

    task automatic test_disable;
        logic [31:0] s;
        logic [1:0] r;
        int hi;
        int lo;
        do_reset(3'h7);
        axi_write(`ADDR_SYSTEM_CONFIG, 32'h0000_0001, r);
        repeat (100) @(posedge clock);
        status(s);
        check({30'h0, s[`ST_SOURCE_LSB +: 2]}, {30'h0, SRC_DIRECT});
        half_runs(hi, lo);
        check(32'(hi), 32'h0000_0012);
    endtask : test_disable

    task automatic finish_test;
        if (mismatches == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    initial begin
        {rst, oscRun, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
        clockSelectStraps = 3'h7;
        {awaddr, araddr, wdata} = 48'h0;
        mismatches = 0;
        comparisons = 0;
        test_bus();
        test_straps();
        test_gates();
        test_failover();
        test_disable();
        finish_test();
    end

    // Whole run needs well under 20000 cycles
    initial begin
        #400000;
        mismatches++;
        finish_test();
    end
endmodule : testbench
